// >>> rtl/tpo_pkg.sv
// Constants, register map and carrier types of the time proportioning output
package tpo_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    // Timebase tick of 100 us; one tenth of a second is 1000 ticks
    localparam int unsigned TICK_US = 100;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000000 * TICK_US;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
    localparam logic [9:0] TICKS_PER_TENTH = 10'h3e8;
    // Power in tenths of a percent
    localparam logic [9:0] FULL_SCALE = 10'h3e8;
    localparam logic signed [12:0] HALF_SCALE_S = 13'sh01f4;
    localparam logic signed [12:0] FULL_SCALE_S = 13'sh03e8;
    // Period in tenths of a second
    localparam logic [9:0] PER_MIN = 10'h001;
    localparam logic [9:0] PER_MIN_RELAY = 10'h032;
    localparam logic [9:0] PER_MAX = 10'h258;
    // Index of the last line cycle in a variable-mode burst step of three
    localparam logic [1:0] LINE_BLK_LAST = 2'h2;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_DEMAND = 5'h04;
    localparam logic [4:0] OFS_PERIOD = 5'h08;
    localparam logic [4:0] OFS_LOW = 5'h0c;
    localparam logic [4:0] OFS_HIGH = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    // Control register bit positions
    localparam int unsigned CTRL_DIGITAL = 0;
    localparam int unsigned CTRL_DIG_ON = 1;
    localparam int unsigned CTRL_VARIABLE = 2;
    localparam int unsigned CTRL_RELAY = 3;
    // Values after reset
    localparam logic [9:0] RST_PERIOD = 10'h064;
    localparam logic [9:0] RST_LOW = 10'h000;
    localparam logic [9:0] RST_HIGH = 10'h3e8;
    localparam logic [9:0] RST_DEMAND = 10'h000;

    typedef struct packed {
        logic digital;
        logic dig_on;
        logic var_sel;
        logic relay;
        logic [9:0] demand;
        logic [9:0] period;
        logic [9:0] low;
        logic [9:0] high;
    } tpo_cfg_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [4:0] adr;
        logic [31:0] dat;
    } tpo_wb_req_t;
endpackage

// >>> rtl/tpo_top.sv
// Time proportioning output driver with a classic Wishbone register slave
//
// Overview of operation
// - Off or zero demand applies the low scale power; the output stays off only with low scale at 0.
// - On or full demand applies the high scale power; the output stays on only with high scale at 100.0.
// - Demands between zero and full switch using the selected time base.
// - A mode bit picks fixed period or line-cycle variable switching.
// - Average on fraction equals the demanded power in both methods.
// - Fixed mode: on for demanded fraction of period, then off, repeating.
// - Fixed period ranges 0.1 to 60.0 seconds in tenth steps.
// - Fixed period is ignored while variable mode is active.
// - Variable mode switches on line edges, at most every three cycles, apart from its first decision when it starts.
// - Variable mode: 66% gives six on three off, 50% three and three.
// - Low scale sets the power applied at zero or off demand.
// - High scale sets the power applied at full or on demand.
// - Demand is mapped linearly between low and high scale.
// - Both scales range 0.0 to 100.0 percent in tenth steps.
// - Relay variant has no variable mode, only fixed period.
// - Relay variant limits the fixed period to 5.0 to 60.0 seconds.
`timescale 1ns/10ps
module tpo_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic line_cyc_i,
    output logic load_on_o
);

    typedef struct packed {
        tpo_pkg::tpo_cfg_t cfg;
        logic [11:0] pre;
        logic [19:0] cnt;
        logic [19:0] per_tk;
        logic [19:0] on_tk;
        logic [9:0] eff_lat;
        logic var_lat;
        logic signed [12:0] acc;
        logic [1:0] blk;
        logic run;
        logic armed;
        logic out;
        logic [2:0] line_s;
        logic ack;
        logic [31:0] dat;
    } tpo_state_t;

    tpo_state_t state_r;
    tpo_state_t state_nxt;
    tpo_pkg::tpo_wb_req_t req;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [9:0] tpo_sat_full(input logic [31:0] v);
        logic [9:0] r;
        r = (v > 32'(tpo_pkg::FULL_SCALE)) ? tpo_pkg::FULL_SCALE : v[9:0];
        return r;
    endfunction

    function automatic logic [9:0] tpo_sat_per(input logic [31:0] v);
        logic [9:0] r;
        r = v[9:0];
        if (v < 32'(tpo_pkg::PER_MIN))
        begin
            r = tpo_pkg::PER_MIN;
        end
        else if (v > 32'(tpo_pkg::PER_MAX))
        begin
            r = tpo_pkg::PER_MAX;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Demand scaling and boundary detection

    logic [9:0] dem;
    logic [9:0] dem_inv;
    logic [20:0] mix;
    logic [9:0] eff;
    logic [9:0] per_use;
    logic new_var;
    logic tick;
    logic line_edge;
    logic fix_last;
    logic boundary;
    logic signed [12:0] acc_sum;
    logic burst_on;

    always_comb
    begin
        req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
        // Digital demand maps to the two ends of the scale
        if (state_r.cfg.digital)
        begin
            dem = state_r.cfg.dig_on ? tpo_pkg::FULL_SCALE : 10'h000;
        end
        else
        begin
            dem = state_r.cfg.demand;
        end
        dem_inv = tpo_pkg::FULL_SCALE - dem;
        // Linear blend between low and high scale
        mix = 21'(state_r.cfg.low * dem_inv) + 21'(state_r.cfg.high * dem);
        eff = 10'(mix / 21'(tpo_pkg::FULL_SCALE));
        // Relay variant never runs variable mode and has a longer least period
        new_var = state_r.cfg.var_sel & ~state_r.cfg.relay;
        per_use = state_r.cfg.period;
        if (state_r.cfg.relay && state_r.cfg.period < tpo_pkg::PER_MIN_RELAY)
        begin
            per_use = tpo_pkg::PER_MIN_RELAY;
        end
        tick = (state_r.pre == tpo_pkg::TICK_LAST);
        line_edge = state_r.line_s[1] & ~state_r.line_s[2];
        fix_last = (state_r.cnt == state_r.per_tk - 20'h00001);
        // New settings take effect only where a period or burst step begins
        // Nothing runs until the first demand has been written after reset
        boundary = (~state_r.run & state_r.armed)
            | (state_r.run & ~state_r.var_lat & tick & fix_last)
            | (state_r.run & state_r.var_lat & line_edge & (state_r.blk == tpo_pkg::LINE_BLK_LAST));
        // First-order error feedback keeps the long-run average exact
        acc_sum = state_r.acc + 13'(eff);
        burst_on = (acc_sum >= tpo_pkg::HALF_SCALE_S);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.line_s = {state_r.line_s[1:0], line_cyc_i};
        state_nxt.pre = tick ? 12'h000 : state_r.pre + 12'h001;

        if (boundary)
        begin
            state_nxt.run = 1'b1;
            state_nxt.var_lat = new_var;
            state_nxt.eff_lat = eff;
            state_nxt.cnt = 20'h00000;
            state_nxt.blk = 2'h0;
            // Period length used only by fixed mode
            state_nxt.per_tk = per_use * tpo_pkg::TICKS_PER_TENTH;
            state_nxt.on_tk = per_use * eff;
            if (new_var)
            begin
                // One decision per three line cycles
                state_nxt.out = burst_on;
                state_nxt.acc = burst_on ? acc_sum - tpo_pkg::FULL_SCALE_S : acc_sum;
            end
            else
            begin
                // Zero on-time holds off, full on-time holds on
                state_nxt.out = (per_use * eff) != 20'h00000;
                state_nxt.acc = 13'sh0000;
            end
        end
        else if (!state_r.var_lat && tick)
        begin
            state_nxt.cnt = state_r.cnt + 20'h00001;
            state_nxt.out = (state_r.cnt + 20'h00001) < state_r.on_tk;
        end
        else if (state_r.var_lat && line_edge)
        begin
            state_nxt.blk = state_r.blk + 2'h1;
        end

        ////////////////////////////////////////////////////////////////////
        // Wishbone slave: ack one cycle after the request, dropped next cycle

        state_nxt.ack = req.cyc & req.stb & ~state_r.ack;
        if (req.cyc && req.stb && !state_r.ack)
        begin
            state_nxt.dat = 32'h00000000;
            unique case (req.adr)
                tpo_pkg::OFS_CTRL:
                begin
                    state_nxt.dat[tpo_pkg::CTRL_DIGITAL] = state_r.cfg.digital;
                    state_nxt.dat[tpo_pkg::CTRL_DIG_ON] = state_r.cfg.dig_on;
                    state_nxt.dat[tpo_pkg::CTRL_VARIABLE] = state_r.cfg.var_sel;
                    state_nxt.dat[tpo_pkg::CTRL_RELAY] = state_r.cfg.relay;
                    if (req.we && req.sel[0])
                    begin
                        state_nxt.cfg.digital = req.dat[tpo_pkg::CTRL_DIGITAL];
                        state_nxt.cfg.dig_on = req.dat[tpo_pkg::CTRL_DIG_ON];
                        state_nxt.cfg.var_sel = req.dat[tpo_pkg::CTRL_VARIABLE];
                        state_nxt.cfg.relay = req.dat[tpo_pkg::CTRL_RELAY];
                    end
                end
                tpo_pkg::OFS_DEMAND:
                begin
                    state_nxt.dat[9:0] = state_r.cfg.demand;
                    if (req.we && req.sel[1:0] == 2'h3)
                    begin
                        state_nxt.cfg.demand = tpo_sat_full(req.dat);
                        state_nxt.armed = 1'b1;
                    end
                end
                tpo_pkg::OFS_PERIOD:
                begin
                    state_nxt.dat[9:0] = state_r.cfg.period;
                    if (req.we && req.sel[1:0] == 2'h3)
                    begin
                        state_nxt.cfg.period = tpo_sat_per(req.dat);
                    end
                end
                tpo_pkg::OFS_LOW:
                begin
                    state_nxt.dat[9:0] = state_r.cfg.low;
                    if (req.we && req.sel[1:0] == 2'h3)
                    begin
                        state_nxt.cfg.low = tpo_sat_full(req.dat);
                    end
                end
                tpo_pkg::OFS_HIGH:
                begin
                    state_nxt.dat[9:0] = state_r.cfg.high;
                    if (req.we && req.sel[1:0] == 2'h3)
                    begin
                        state_nxt.cfg.high = tpo_sat_full(req.dat);
                    end
                end
                tpo_pkg::OFS_STATUS:
                begin
                    state_nxt.dat[0] = state_r.out;
                    state_nxt.dat[1] = state_r.var_lat;
                    state_nxt.dat[2] = state_r.run;
                    state_nxt.dat[25:16] = state_r.eff_lat;
                end
                default:
                begin
                    state_nxt.dat = 32'h00000000;
                end
            endcase
            // Writes return zero read data
            if (req.we)
            begin
                state_nxt.dat = 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= '0;
            state_r.cfg.period <= tpo_pkg::RST_PERIOD;
            state_r.cfg.low <= tpo_pkg::RST_LOW;
            state_r.cfg.high <= tpo_pkg::RST_HIGH;
            state_r.cfg.demand <= tpo_pkg::RST_DEMAND;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign load_on_o = state_r.out;
    assign wb_ack_o = state_r.ack;
    assign wb_dat_o = state_r.dat;

endmodule

// >>> testbench/tpo_monitor.sv
// Concurrent checks on the ports of the time proportioning output
`timescale 1ns/10ps
module tpo_monitor
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic line_cyc_i,
    input wire logic load_on_o
);
    logic take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ack;
        take |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not given");
    property p_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
    property p_idle;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_idle: assert property (p_idle) else $error("ack without request");
    property p_wdat;
        take && wb_we_i |=> wb_dat_o == 32'h0;
    endproperty
    a_wdat: assert property (p_wdat) else $error("read data on write");
    property p_unmap;
        take && !wb_we_i && wb_adr_i > 5'h14 |=> wb_dat_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_upper;
        wb_ack_o |-> wb_dat_o[31:26] == 6'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_stat;
        take && !wb_we_i && wb_adr_i == tpo_pkg::OFS_STATUS |=> wb_dat_o[0] == $past(load_on_o) && wb_dat_o[15:3] == 13'h0;
    endproperty
    a_stat: assert property (p_stat) else $error("status output bit wrong");
    property p_rst;
        @(posedge clk_i) disable iff (1'b0) rst_i |=> !load_on_o && !wb_ack_o && wb_dat_o == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active in reset");
    property p_dwell;
        $changed(load_on_o) |=> $stable(load_on_o)[*8];
    endproperty
    a_dwell: assert property (p_dwell) else $error("output switched too soon");
    c_wr: cover property (take && wb_we_i);
    c_rd: cover property (take && !wb_we_i && wb_adr_i == tpo_pkg::OFS_STATUS);
    c_line: cover property ($rose(line_cyc_i));
endmodule
bind tpo_top tpo_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .line_cyc_i(line_cyc_i), .load_on_o(load_on_o));

// >>> testbench/tpo_load_model.sv
// Load switch and ac line source at the far side of the output
`timescale 1ns/10ps
module tpo_load_model
#(
    parameter int LINE_CLKS = 8
)
(
    input wire logic clk_i,
    input wire logic line_en_i,
    input wire logic load_on_i,
    output logic line_cyc_o,
    output int on_count_o
);
    int phase;
    initial
    begin
        phase = 0;
        line_cyc_o = 1'b0;
        on_count_o = 0;
    end
    // Line strobe stands still while disabled, half high otherwise
    always @(posedge clk_i)
    begin
        phase <= (phase == LINE_CLKS - 1) ? 0 : phase + 1;
        line_cyc_o <= line_en_i && (phase < LINE_CLKS / 2);
        if (load_on_i)
            on_count_o <= on_count_o + 1;
    end
endmodule

// >>> testbench/tpo_tb.sv
// Self-checking bench of the time proportioning output
`timescale 1ns/10ps
module tpo_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    tpo_pkg::tpo_wb_req_t req = '0;
    logic [31:0] dat_o;
    logic ack_o;
    logic line_cyc;
    logic load_on;
    logic line_en = 1'b0;
    int on_cnt;
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] rd;
    always #20 clk_i = ~clk_i;
    tpo_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
        .line_cyc_i(line_cyc), .load_on_o(load_on));
    tpo_load_model u_load (.clk_i(clk_i), .line_en_i(line_en), .load_on_i(load_on), .line_cyc_o(line_cyc),
        .on_count_o(on_cnt));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
        do
        begin
            @(posedge clk_i);
            n++;
            if (n > 20)
            begin
                bad_count++;
                end_sim();
            end
        end
        while (ack_o !== 1'b1);
        rd = dat_o;
        req <= '0;
        @(posedge clk_i);
    endtask
    task automatic wrc(input logic [4:0] adr, input logic [31:0] dat, input logic [3:0] sel, input logic [31:0] exp);
        wb(1'b1, adr, dat, sel);
        wb(1'b0, adr, 32'h0, 4'hf);
        check("readback", rd, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] e[6] = '{32'h0, 32'h0, 32'h64, 32'h0, 32'h3e8, 32'h0};
        for (int i = 0; i < 6; i++)
        begin
            wb(1'b0, 5'(i * 4), 32'h0, 4'hf);
            check("reset value", rd, e[i]);
        end
        check("load", 32'(load_on), 32'h0);
        $display("test reset done");
    endtask
    task automatic t_fields();
        wrc(tpo_pkg::OFS_DEMAND, 32'h7ff, 4'hf, 32'h3e8);
        wrc(tpo_pkg::OFS_PERIOD, 32'h0, 4'hf, 32'h1);
        wrc(tpo_pkg::OFS_PERIOD, 32'h3ff, 4'hf, 32'h258);
        wrc(tpo_pkg::OFS_LOW, 32'h3e9, 4'hf, 32'h3e8);
        wrc(tpo_pkg::OFS_HIGH, 32'h1f4, 4'h1, 32'h3e8);
        wrc(tpo_pkg::OFS_HIGH, 32'h1f4, 4'h3, 32'h1f4);
        wrc(tpo_pkg::OFS_CTRL, 32'ha, 4'hf, 32'ha);
        wrc(tpo_pkg::OFS_PERIOD, 32'ha, 4'hf, 32'ha);
        wrc(5'h18, 32'h3ff, 4'hf, 32'h0);
        wrc(tpo_pkg::OFS_STATUS, 32'h3ff, 4'hf, 32'h03e80005);
        $display("test fields done");
    endtask
    task automatic t_latch();
        int v0;
        wrc(tpo_pkg::OFS_CTRL, 32'h7, 4'hf, 32'h7);
        wrc(tpo_pkg::OFS_LOW, 32'h0, 4'hf, 32'h0);
        line_en <= 1'b1;
        v0 = on_cnt;
        repeat (320) @(posedge clk_i);
        line_en <= 1'b0;
        check("on time", 32'(on_cnt - v0), 32'h140);
        wb(1'b0, tpo_pkg::OFS_STATUS, 32'h0, 4'hf);
        check("status", rd, 32'h03e80005);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, tpo_pkg::OFS_CTRL, 32'h0, 4'hf);
        check("ctrl", rd, 32'h0);
        check("load", 32'(load_on), 32'h0);
        $display("test latch done");
    endtask
    task automatic t_var();
        int v0;
        wrc(tpo_pkg::OFS_CTRL, 32'h4, 4'hf, 32'h4);
        wb(1'b1, tpo_pkg::OFS_DEMAND, 32'h1f4, 4'hf);
        line_en <= 1'b1;
        v0 = on_cnt;
        repeat (384) @(posedge clk_i);
        check("half duty", 32'((on_cnt - v0) >= 160 && (on_cnt - v0) <= 224), 32'h1);
        wb(1'b0, tpo_pkg::OFS_STATUS, 32'h0, 4'hf);
        check("var latched", 32'({rd[25:16], rd[2:1]}), 32'h7d3);
        wb(1'b1, tpo_pkg::OFS_LOW, 32'hc8, 4'hf);
        wb(1'b1, tpo_pkg::OFS_HIGH, 32'h258, 4'hf);
        repeat (48) @(posedge clk_i);
        wb(1'b0, tpo_pkg::OFS_STATUS, 32'h0, 4'hf);
        check("scaled power", 32'(rd[25:16]), 32'h190);
        line_en <= 1'b0;
        $display("test variable done");
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_fields();
        t_latch();
        t_var();
        end_sim();
    end
endmodule
